// ==== common/link_cfg_consts.vh ====
// constants for the link controller configuration registers
`ifndef LINK_CFG_CONSTS_VH
`define LINK_CFG_CONSTS_VH

// ***********************************************
// register addresses (own choice, byte map)
// ***********************************************
`define ADDR_DELAY_CFG      3'h0
`define ADDR_CONTROL_ONE    3'h1
`define ADDR_STATE_VECTOR   3'h2
`define ADDR_STATUS         3'h3

// ***********************************************
// transceiver_delay_config fields
// ***********************************************
`define DLY_XCVR_SEL_BIT    6
`define DLY_RX_POL_BIT      5
`define DLY_OFFSET_LSB      0
`define DLY_RESET_VAL       8'h07
`define DLY_BASE_US         5'h09
`define DLY_RESET_US        5'h10

// ***********************************************
// link_control_one fields
// ***********************************************
`define C1_IGNORE_BIT       7
`define C1_CLK_SEL_BIT      6
`define C1_RATE_HI_BIT      3
`define C1_RATE_LO_BIT      2
`define C1_IE_BIT           1
`define C1_WCM_BIT          0
`define C1_RESET_VAL        8'h00

// ***********************************************
// state vector codes
// ***********************************************
`define SV_IDLE             8'h00
`define SV_INVALID_SYM      8'h1C

`endif

// ==== verilog/rate_divider.v ====
// rate divider making the link timing enable pulse from the crystal enable
`timescale 1ns/1ps
`include "link_cfg_consts.vh"

module rate_divider #(
    parameter CNT_W = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // control
    input  wire [1:0]       rate_code,
    input  wire             xtal_tick,
    input  wire             hold,
    // output
    output reg              link_tick
);

    reg  [CNT_W-1:0] cnt_q;
    wire [CNT_W-1:0] last;

    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    // divide by 1, 2, 4 or 8; the shift wraps to zero at 8 so last is 7
    assign last = (CNT_ONE << rate_code) - CNT_ONE;

    // counter wraps on terminal count, gated by wait clock stop
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q     <= {CNT_W{1'b0}};
            link_tick <= 1'b0;
        end else begin
            link_tick <= 1'b0;
            if (xtal_tick && !hold) begin
                if (cnt_q >= last) begin
                    cnt_q     <= {CNT_W{1'b0}};
                    link_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

// ==== verilog/rx_pin_sync.v ====
// three flop synchroniser for the receive pin with polarity select
`timescale 1ns/1ps

module rx_pin_sync (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // pin and polarity
    input  wire             rx_pin,
    input  wire             true_pol,
    // synchronised bus state, 1 = active
    output reg              bus_active
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first flop only feeds second; change accepted when 2 and 3 agree
    always @(posedge clk) begin
        if (sys_rst) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            bus_active <= 1'b0;
        end else begin
            s1_q <= rx_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                bus_active <= true_pol ? s3_q : ~s3_q;
            end
        end
    end

endmodule

// ==== verilog/j1850_link_cpu_config_regs.v ====
// configuration and control registers of the j1850 link controller
// Functional notes
// - delay register takes only first write after reset, readable always
// - offset code maps to 9 us plus one us per step, up to 24
// - after reset the compensated delay is 16 us
// - transceiver select 1 on-board, 0 off-chip; software writes 0
// - receive polarity 1 takes pin true, 0 inverted
// - ignore bit disables receiver, masks requests, holds status at reset
// - ignore bit clears itself on start-of-frame or break
// - clock select picks 1.048576 MHz or 1 MHz symbol scaling
// - rate code 00..11 divides crystal clock by 1, 2, 4, 8
// - rate bits take only first write after reset
// - interrupt enable gates run mode requests, not wake requests
// - request held until every source cleared; disable may drop pending
// - wait clock mode stops internal clocks in cpu wait when 1
// - reading the state vector clears pending invalid symbol condition
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "link_cfg_consts.vh"

module j1850_link_cpu_config_regs (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // register port
    input  wire [2:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    // timing source and power modes
    input  wire             xtal_tick,
    input  wire             cpu_wait,
    input  wire             low_power_mode,
    input  wire             wake_event,
    // receive pin and link state machine events
    input  wire             rx_pin,
    input  wire             sof_seen,
    input  wire             break_seen,
    input  wire             invalid_symbol,
    // to link state machine
    output reg              rx_bus_active,
    output reg              rx_enable,
    output reg              link_tick,
    output reg              clk_binary_sel,
    output reg              onboard_xcvr_sel,
    output reg  [4:0]       xcvr_delay_us,
    output reg              clocks_stopped,
    output reg              irq
);

    // ***********************************************
    // registers
    // ***********************************************
    // delay register and its write-once lock
    reg  [7:0] delay_cfg_q;
    reg        delay_locked_q;
    // control one fields and the rate lock
    reg        ignore_q;
    reg        ignore_d;
    reg        clk_sel_q;
    reg  [1:0] rate_q;
    reg        rate_locked_q;
    reg        ie_q;
    reg        wcm_q;
    // pending request sources
    reg        inv_pend_q;
    reg        wake_pend_q;
    // decoded accesses and sub block results
    wire       wr_dly;
    wire       wr_c1;
    wire       rd_sv;
    wire       stop_clk;
    wire       tick_raw;
    wire       bus_act_raw;
    // readback words
    wire [7:0] ctl_one;
    wire [7:0] state_vec;
    wire [7:0] status_word;

    // delay code to microseconds
    function [4:0] delay_of;
        input [3:0] code;
        begin
            delay_of = `DLY_BASE_US + {1'b0, code};
        end
    endfunction

    // address match, shared by every strobe decode
    function addr_hit;
        input [2:0] addr;
        input [2:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // read multiplexer; unmapped addresses read as zero
    function [7:0] read_mux;
        input [2:0] addr;
        input [7:0] dly;
        input [7:0] c1;
        input [7:0] sv;
        input [7:0] stat;
        begin
            case (addr)
                `ADDR_DELAY_CFG:    read_mux = dly;
                `ADDR_CONTROL_ONE:  read_mux = c1;
                `ADDR_STATE_VECTOR: read_mux = sv;
                `ADDR_STATUS:       read_mux = stat;
                default:            read_mux = 8'h00;
            endcase
        end
    endfunction

    // ***********************************************
    // access decode
    // ***********************************************
    assign wr_dly   = reg_wr && addr_hit(reg_addr, `ADDR_DELAY_CFG);
    assign wr_c1    = reg_wr && addr_hit(reg_addr, `ADDR_CONTROL_ONE);
    assign rd_sv    = reg_rd && addr_hit(reg_addr, `ADDR_STATE_VECTOR);

    // ***********************************************
    // clock hold
    // ***********************************************
    // divider holds only when wait mode and the wait clock bit are both set
    assign stop_clk = cpu_wait && wcm_q;

    // ***********************************************
    // readback words
    // ***********************************************
    assign ctl_one = {ignore_q, clk_sel_q, 2'b00, rate_q, ie_q, wcm_q};
    assign status_word = {5'h00, wake_pend_q, rate_locked_q, delay_locked_q};
    // status held at reset code while ignoring
    assign state_vec = (inv_pend_q && !ignore_q) ? `SV_INVALID_SYM : `SV_IDLE;

    // ***********************************************
    // sub blocks
    // ***********************************************
    rate_divider #(
        .CNT_W (3)
    ) u_div (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .rate_code (rate_q),
        .xtal_tick (xtal_tick),
        .hold      (stop_clk),
        .link_tick (tick_raw)
    );

    rx_pin_sync u_sync (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .rx_pin     (rx_pin),
        .true_pol   (delay_cfg_q[`DLY_RX_POL_BIT]),
        .bus_active (bus_act_raw)
    );

    // ***********************************************
    // delay register, one write per reset
    // ***********************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            delay_cfg_q    <= `DLY_RESET_VAL;
            delay_locked_q <= 1'b0;
        end else if (wr_dly && !delay_locked_q) begin
            delay_cfg_q    <= reg_wdata & 8'h6F;
            delay_locked_q <= 1'b1;
        end
    end

    // ***********************************************
    // control one
    // ***********************************************
    // ignore next value; self clear on sof or break, only while the bit is already set, wins over a write
    always @* begin
        ignore_d = ignore_q;
        if (wr_c1) begin
            ignore_d = reg_wdata[`C1_IGNORE_BIT];
        end
        if (ignore_q && (sof_seen || break_seen)) begin
            ignore_d = 1'b0;
        end
    end

    // control one fields; rate bits lock on the first write
    always @(posedge clk) begin
        if (sys_rst) begin
            ignore_q      <= 1'b0;
            clk_sel_q     <= 1'b0;
            rate_q        <= 2'b00;
            rate_locked_q <= 1'b0;
            ie_q          <= 1'b0;
            wcm_q         <= 1'b0;
        end else begin
            ignore_q <= ignore_d;
            if (wr_c1) begin
                clk_sel_q <= reg_wdata[`C1_CLK_SEL_BIT];
                ie_q      <= reg_wdata[`C1_IE_BIT];
                wcm_q     <= reg_wdata[`C1_WCM_BIT];
                if (!rate_locked_q) begin
                    rate_q        <= {reg_wdata[`C1_RATE_HI_BIT], reg_wdata[`C1_RATE_LO_BIT]};
                    rate_locked_q <= 1'b1;
                end
            end
        end
    end

    // ***********************************************
    // interrupt sources
    // ***********************************************
    // a new event in the read cycle is kept: set wins over clear
    always @(posedge clk) begin
        if (sys_rst) begin
            inv_pend_q  <= 1'b0;
            wake_pend_q <= 1'b0;
        end else begin
            if (ignore_q) begin
                inv_pend_q <= 1'b0;
            end else if (invalid_symbol) begin
                inv_pend_q <= 1'b1;
            end else if (rd_sv) begin
                inv_pend_q <= 1'b0;
            end else if (wr_c1 && !reg_wdata[`C1_IE_BIT]) begin
                inv_pend_q <= 1'b0;
            end
            if (wake_event && low_power_mode) begin
                wake_pend_q <= 1'b1;
            end else if (rd_sv) begin
                wake_pend_q <= 1'b0;
            end
        end
    end

    // ***********************************************
    // receive path outputs
    // ***********************************************
    // receiver gate follows the ignore bit one cycle late
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_bus_active <= 1'b0;
            rx_enable     <= 1'b0;
        end else begin
            rx_bus_active <= bus_act_raw;
            rx_enable     <= ~ignore_q;
        end
    end

    // ***********************************************
    // timing and transceiver outputs
    // ***********************************************
    // registered so the link side never sees decode glitches
    always @(posedge clk) begin
        if (sys_rst) begin
            link_tick        <= 1'b0;
            clk_binary_sel   <= 1'b0;
            onboard_xcvr_sel <= 1'b0;
            xcvr_delay_us    <= `DLY_RESET_US;
        end else begin
            link_tick        <= tick_raw;
            clk_binary_sel   <= clk_sel_q;
            onboard_xcvr_sel <= delay_cfg_q[`DLY_XCVR_SEL_BIT];
            xcvr_delay_us    <= delay_of(delay_cfg_q[3:0]);
        end
    end

    // ***********************************************
    // power mode output
    // ***********************************************
    // tells the link side that the divider is held
    always @(posedge clk) begin
        if (sys_rst) begin
            clocks_stopped <= 1'b0;
        end else begin
            clocks_stopped <= stop_clk;
        end
    end

    // ***********************************************
    // interrupt request
    // ***********************************************
    // wake requests bypass enable; run requests need it
    always @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= !ignore_q && ((inv_pend_q && ie_q) || wake_pend_q);
        end
    end

    // ***********************************************
    // read data
    // ***********************************************
    // zero outside the read slot, so a stale word never looks valid
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= read_mux(reg_addr, delay_cfg_q, ctl_one, state_vec, status_word);
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ==== sim/cfg_regs_monitor.sv ====
// port checker for the link controller configuration registers
`timescale 1ns/1ps
`include "link_cfg_consts.vh"

module cfg_regs_monitor (
    // clock and reset
    input wire       clk,
    input wire       sys_rst,
    // register port
    input wire [2:0] reg_addr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // events and modes
    input wire       cpu_wait,
    input wire       sof_seen,
    input wire       break_seen,
    // outputs under watch
    input wire       rx_enable,
    input wire       onboard_xcvr_sel,
    input wire [4:0] xcvr_delay_us,
    input wire       clocks_stopped,
    input wire       irq
);
    // ***********************
    // properties
    // ***********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
    delay_range_a: assert property (xcvr_delay_us >= 5'h09 && xcvr_delay_us <= 5'h18)
        else $error("delay out of range");
    rst_delay_a: assert property ($fell(sys_rst) |-> xcvr_delay_us == 5'h10) else $error("reset delay wrong");
    // readback and decoded output must agree
    dly_map_a: assert property ($past(reg_rd) && $past(reg_addr) == `ADDR_DELAY_CFG
        |-> xcvr_delay_us == {1'b0, reg_rdata[3:0]} + 5'h09 && onboard_xcvr_sel == reg_rdata[6])
        else $error("delay output mismatch");
    sof_clear_a: assert property (sof_seen |-> ##2 rx_enable) else $error("sof did not clear ignore");
    brk_clear_a: assert property (break_seen |-> ##2 rx_enable) else $error("break did not clear ignore");
    irq_mask_a: assert property (irq |-> rx_enable) else $error("request while ignoring");
    clk_stop_a: assert property (clocks_stopped |-> $past(cpu_wait)) else $error("clocks stopped outside wait");
    sv_code_a: assert property ($past(reg_rd) && $past(reg_addr) == `ADDR_STATE_VECTOR
        |-> reg_rdata == `SV_IDLE || reg_rdata == `SV_INVALID_SYM) else $error("bad state vector");
endmodule

bind j1850_link_cpu_config_regs cfg_regs_monitor mon (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
    .cpu_wait, .sof_seen, .break_seen, .rx_enable, .onboard_xcvr_sel, .xcvr_delay_us, .clocks_stopped, .irq);

// ==== sim/link_far_side.sv ====
// model of the transceiver and link state machine events
`timescale 1ns/1ps

module link_far_side (
    // clock
    input wire clk,
    // toward the registers
    output reg xtal_tick,
    output reg rx_pin,
    output reg sof_seen,
    output reg break_seen,
    output reg invalid_symbol,
    output reg wake_event
);
    // ***********************
    // stimulus
    // ***********************
    // crystal enable every other cycle: a crystal at half the system rate
    always @(posedge clk) begin
        xtal_tick <= (xtal_tick === 1'b1) ? 1'b0 : 1'b1;
    end
    // idle levels at time zero
    initial begin
        rx_pin = 1'b0;
        {sof_seen, break_seen, invalid_symbol, wake_event} = 4'h0;
    end
    // one-cycle event: 0 sof, 1 break, 2 invalid symbol, 3 wake
    task ev(input [1:0] k);
        begin
            @(posedge clk);
            {sof_seen, break_seen, invalid_symbol, wake_event} <= 4'h8 >> k;
            @(posedge clk);
            {sof_seen, break_seen, invalid_symbol, wake_event} <= 4'h0;
        end
    endtask
    task pin(input v);
        begin
            @(posedge clk);
            rx_pin <= v;
        end
    endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the configuration registers
`timescale 1ns/1ps
`include "link_cfg_consts.vh"

module testbench;
    reg        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, cpu_wait = 0, low_power_mode = 0;
    reg  [2:0] reg_addr = 0;
    reg  [7:0] reg_wdata = 0, d;
    wire [7:0] reg_rdata;
    wire [4:0] xcvr_delay_us;
    wire       xtal_tick, rx_pin, sof_seen, break_seen, invalid_symbol, wake_event;
    wire       rx_bus_active, rx_enable, link_tick, clk_binary_sel, onboard_xcvr_sel, clocks_stopped, irq;
    integer    err_count = 0, check_count = 0, i, n;

    always #2.5 clk = ~clk;

    j1850_link_cpu_config_regs uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .xtal_tick, .cpu_wait, .low_power_mode, .wake_event, .rx_pin, .sof_seen, .break_seen, .invalid_symbol,
        .rx_bus_active, .rx_enable, .link_tick, .clk_binary_sel, .onboard_xcvr_sel, .xcvr_delay_us,
        .clocks_stopped, .irq);
    link_far_side far (.clk, .xtal_tick, .rx_pin, .sof_seen, .break_seen, .invalid_symbol, .wake_event);

    // ***********************
    // helpers
    // ***********************
    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] v);
        begin
            @(posedge clk);
            {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task rc(input [2:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, exp);
        end
    endtask
    task idle(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    // counts link_tick pulses over c cycles into n
    task count_ticks(input integer c);
        begin
            n = 0;
            repeat (c) begin
                @(posedge clk);
                #1 n = n + link_tick;
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (err_count == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // ***********************
    // tests
    // ***********************
    // bound kept well above the few hundred cycles the tests need
    initial begin
        #60000;
        err_count = err_count + 1;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`ADDR_DELAY_CFG, 8'h07);
        chk({3'h0, xcvr_delay_us}, 8'h10);
        rc(`ADDR_CONTROL_ONE, 8'h00);
        rc(3'h5, 8'h00);
        wr(`ADDR_DELAY_CFG, 8'h2F);
        rc(`ADDR_DELAY_CFG, 8'h2F);
        chk({3'h0, xcvr_delay_us}, 8'h18);
        wr(`ADDR_DELAY_CFG, 8'h40);
        rc(`ADDR_DELAY_CFG, 8'h2F);
        far.pin(1'b1);
        idle(6);
        chk(rx_bus_active, 1'b1);
        far.pin(1'b0);
        idle(6);
        chk(rx_bus_active, 1'b0);
        wr(`ADDR_CONTROL_ONE, 8'hCE);
        rc(`ADDR_CONTROL_ONE, 8'hCE);
        chk(rx_enable, 1'b0);
        chk(clk_binary_sel, 1'b1);
        far.ev(2);
        idle(3);
        chk(irq, 1'b0);
        rc(`ADDR_STATE_VECTOR, `SV_IDLE);
        far.ev(0);
        idle(3);
        chk(rx_enable, 1'b1);
        rc(`ADDR_CONTROL_ONE, 8'h4E);
        wr(`ADDR_CONTROL_ONE, 8'h02);
        rc(`ADDR_CONTROL_ONE, 8'h0E);
        far.ev(2);
        idle(8);
        chk(irq, 1'b1);
        rc(`ADDR_STATE_VECTOR, `SV_INVALID_SYM);
        idle(2);
        chk(irq, 1'b0);
        rc(`ADDR_STATE_VECTOR, `SV_IDLE);
        wr(`ADDR_CONTROL_ONE, 8'h80);
        far.ev(1);
        idle(3);
        chk(rx_enable, 1'b1);
        wr(`ADDR_CONTROL_ONE, 8'h01);
        @(posedge clk) cpu_wait <= 1'b1;
        idle(3);
        chk(clocks_stopped, 1'b1);
        count_ticks(16);
        chk(n[7:0], 8'h00);
        @(posedge clk) cpu_wait <= 1'b0;
        idle(3);
        chk(clocks_stopped, 1'b0);
        far.ev(2);
        idle(3);
        chk(irq, 1'b0);
        @(posedge clk) low_power_mode <= 1'b1;
        far.ev(3);
        idle(3);
        chk(irq, 1'b1);
        @(posedge clk) low_power_mode <= 1'b0;
        rc(`ADDR_STATE_VECTOR, `SV_INVALID_SYM);
        idle(2);
        chk(irq, 1'b0);
        // every rate code needs a fresh reset, the bits lock on first write
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk);
            sys_rst <= 1'b1;
            repeat (3) @(posedge clk);
            sys_rst <= 1'b0;
            wr(`ADDR_DELAY_CFG, 8'h00);
            wr(`ADDR_CONTROL_ONE, {4'h0, i[1:0], 2'b00});
            idle(8);
            count_ticks(64);
            chk(n[7:0], 8'h20 >> i);
            chk(rx_bus_active, 1'b1);
            chk({3'h0, xcvr_delay_us}, 8'h09);
        end
        tally_and_finish;
    end
endmodule
